// ==== logic/pwf_defines.svh ====
`ifndef PWF_DEFINES_SVH
`define PWF_DEFINES_SVH

// register map, 4-bit address
`define PWF_ADDR_PFLAG 4'h0
`define PWF_ADDR_WFLAG 4'h1
`define PWF_ADDR_PEN 4'h2
`define PWF_ADDR_WEDGE 4'h3
`define PWF_ADDR_WEN 4'h4
`define PWF_ADDR_STAT 4'h5
`define PWF_ADDR_MASK 4'h6

// peripheral flag bit positions
`define PWF_BIT_DT 7
`define PWF_BIT_AD 6
`define PWF_BIT_RSV 5
`define PWF_BIT_TG 4
`define PWF_BIT_TFH 3
`define PWF_BIT_TFL 2
`define PWF_BIT_TC 1
`define PWF_BIT_EC 0

// hardware-set flag bits (reserved bit excluded)
`define PWF_FLAG_MASK 8'hdf
`define PWF_RST_BYTE 8'h00
`define PWF_CNT_MAX 8'hff
`define PWF_CNT_ZERO 8'h00

// interrupt status bits
`define PWF_ST_W 2
`define PWF_ST_PERIPH 0
`define PWF_ST_WAKE 1
`define PWF_ST_RST 2'h0

`endif

// ==== logic/pwf_pkg.sv ====
package pwf_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } pwf_bus_req_t;

    typedef struct packed {
        logic sleep_direct;
        logic direct_transfer_on;
        logic converter_start_busy;
        logic tg_capture_edge;
        logic timer_g_capture_pin;
        logic tg_overflow;
        logic overflow_irq_enable;
        logic tf_mode16;
        logic [7:0] timer_f_count_high;
        logic [7:0] timer_f_count_low;
        logic [7:0] timer_f_compare_high;
        logic [7:0] timer_f_compare_low;
        logic [7:0] timer_c_count;
        logic ec_mode16;
        logic event_count_high_ovf;
        logic event_count_low_ovf;
    } pwf_periph_ev_t;

endpackage

// ==== logic/pwf_irq_flags.sv ====
// Chosen here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "pwf_defines.svh"
module pwf_irq_flags
    import pwf_pkg::*;
#(
    parameter int NUM_WKP = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // register port
    input wire pwf_bus_req_t bus_req,
    output logic [7:0] rdata,
    // event sources
    input wire pwf_periph_ev_t periph_ev,
    input wire logic [NUM_WKP-1:0] wakeup_pin,
    input wire logic [NUM_WKP-1:0] wakeup_pin_sel,
    // requests to the interrupt controller
    output logic [7:0] periph_irq_req,
    output logic wakeup_irq_req,
    output logic irq
);

    // ****************************************
    // elaboration check
    // ****************************************
    if (NUM_WKP < 1 || NUM_WKP > 8) begin : g_bad_wkp
        $error("NUM_WKP must lie in 1..8");
    end

    // ****************************************
    // registers and decode
    // ****************************************
    logic [7:0] peripheral_flag_reg_q;
    logic [NUM_WKP-1:0] wakeup_flag_reg_q;
    logic [7:0] periph_enable_q;
    logic [NUM_WKP-1:0] wakeup_edge_select_q;
    logic wakeup_irq_enable_q;
    logic [`PWF_ST_W-1:0] status_q;
    logic [`PWF_ST_W-1:0] mask_q;
    logic [`PWF_ST_W-1:0] status_d;
    logic [7:0] rdata_q;
    logic [7:0] periph_irq_req_q;
    logic wakeup_irq_req_q;
    logic irq_q;

    logic sample_valid_q;
    logic conv_busy_prev_q;
    logic [7:0] tc_prev_q;
    logic tfh_match_prev_q;
    logic tfl_match_prev_q;
    logic [NUM_WKP-1:0] wkp_prev_q;

    logic wr_pflag;
    logic wr_wflag;
    logic rd_stat;
    logic tfh_match;
    logic tfl_match;
    logic [7:0] periph_set;
    logic [NUM_WKP-1:0] wake_set;
    logic [7:0] wflag_rd;

    assign wr_pflag = bus_req.wr && bus_req.addr == `PWF_ADDR_PFLAG;
    assign wr_wflag = bus_req.wr && bus_req.addr == `PWF_ADDR_WFLAG;
    assign rd_stat = bus_req.rd && bus_req.addr == `PWF_ADDR_STAT;

    // ****************************************
    // event detection
    // ****************************************
    // previous samples are only trusted after one clean cycle, so no edge is faked out of reset
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sample_valid_q <= 1'b0;
            conv_busy_prev_q <= 1'b0;
            tc_prev_q <= `PWF_CNT_ZERO;
            tfh_match_prev_q <= 1'b0;
            tfl_match_prev_q <= 1'b0;
            wkp_prev_q <= '0;
        end else begin
            sample_valid_q <= 1'b1;
            conv_busy_prev_q <= periph_ev.converter_start_busy;
            tc_prev_q <= periph_ev.timer_c_count;
            tfh_match_prev_q <= tfh_match;
            tfl_match_prev_q <= tfl_match;
            wkp_prev_q <= wakeup_pin;
        end
    end

    // compare matches set on the rising match so a standing match can still be cleared
    always_comb begin
        if (periph_ev.tf_mode16) begin
            tfh_match = {periph_ev.timer_f_count_high, periph_ev.timer_f_count_low} ==
                        {periph_ev.timer_f_compare_high, periph_ev.timer_f_compare_low};
        end else begin
            tfh_match = periph_ev.timer_f_count_high == periph_ev.timer_f_compare_high;
        end
        tfl_match = !periph_ev.tf_mode16 &&
                    periph_ev.timer_f_count_low == periph_ev.timer_f_compare_low;
    end

    always_comb begin
        periph_set = `PWF_RST_BYTE;
        periph_set[`PWF_BIT_DT] = periph_ev.sleep_direct && periph_ev.direct_transfer_on;
        periph_set[`PWF_BIT_AD] = sample_valid_q && conv_busy_prev_q &&
                                  !periph_ev.converter_start_busy;
        periph_set[`PWF_BIT_TG] = (periph_ev.tg_capture_edge && periph_ev.timer_g_capture_pin) ||
                                  (periph_ev.tg_overflow && periph_ev.overflow_irq_enable);
        periph_set[`PWF_BIT_TFH] = sample_valid_q && tfh_match && !tfh_match_prev_q;
        periph_set[`PWF_BIT_TFL] = sample_valid_q && tfl_match && !tfl_match_prev_q;
        periph_set[`PWF_BIT_TC] = sample_valid_q &&
            ((tc_prev_q == `PWF_CNT_MAX && periph_ev.timer_c_count == `PWF_CNT_ZERO) ||
             (tc_prev_q == `PWF_CNT_ZERO && periph_ev.timer_c_count == `PWF_CNT_MAX));
        if (periph_ev.ec_mode16) begin
            periph_set[`PWF_BIT_EC] = periph_ev.event_count_high_ovf;
        end else begin
            periph_set[`PWF_BIT_EC] = periph_ev.event_count_high_ovf ||
                                      periph_ev.event_count_low_ovf;
        end
    end

    // edge select 0 falling, 1 rising
    always_comb begin
        for (int i = 0; i < NUM_WKP; i++) begin
            if (wakeup_edge_select_q[i]) begin
                wake_set[i] = sample_valid_q && wakeup_pin_sel[i] && !wkp_prev_q[i] && wakeup_pin[i];
            end else begin
                wake_set[i] = sample_valid_q && wakeup_pin_sel[i] && wkp_prev_q[i] && !wakeup_pin[i];
            end
        end
    end

    // ****************************************
    // flag registers
    // ****************************************
    // taking the interrupt never touches the flags; only a write of 0 does
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            peripheral_flag_reg_q <= `PWF_RST_BYTE;
        end else if (wr_pflag) begin
            peripheral_flag_reg_q <= (peripheral_flag_reg_q & bus_req.wdata & `PWF_FLAG_MASK) |
                                     (bus_req.wdata & ~`PWF_FLAG_MASK) | periph_set;
        end else begin
            peripheral_flag_reg_q <= peripheral_flag_reg_q | periph_set;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wakeup_flag_reg_q <= '0;
        end else if (wr_wflag) begin
            wakeup_flag_reg_q <= (wakeup_flag_reg_q & bus_req.wdata[NUM_WKP-1:0]) | wake_set;
        end else begin
            wakeup_flag_reg_q <= wakeup_flag_reg_q | wake_set;
        end
    end

    // ****************************************
    // control registers
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            periph_enable_q <= `PWF_RST_BYTE;
            wakeup_edge_select_q <= '0;
            wakeup_irq_enable_q <= 1'b0;
            mask_q <= `PWF_ST_RST;
        end else if (bus_req.wr) begin
            case (bus_req.addr)
                `PWF_ADDR_PEN: periph_enable_q <= bus_req.wdata;
                `PWF_ADDR_WEDGE: wakeup_edge_select_q <= bus_req.wdata[NUM_WKP-1:0];
                `PWF_ADDR_WEN: wakeup_irq_enable_q <= bus_req.wdata[0];
                `PWF_ADDR_MASK: mask_q <= bus_req.wdata[`PWF_ST_W-1:0];
                default: ;
            endcase
        end
    end

    // ****************************************
    // requests to the controller
    // ****************************************
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            periph_irq_req_q <= `PWF_RST_BYTE;
            wakeup_irq_req_q <= 1'b0;
        end else begin
            periph_irq_req_q <= peripheral_flag_reg_q & periph_enable_q & `PWF_FLAG_MASK;
            wakeup_irq_req_q <= (|wakeup_flag_reg_q) && wakeup_irq_enable_q;
        end
    end

    // ****************************************
    // interrupt status, mask and line
    // ****************************************
    // a new event in the reading cycle survives the read-clear
    always_comb begin
        status_d = rd_stat ? `PWF_ST_RST : status_q;
        status_d[`PWF_ST_PERIPH] = status_d[`PWF_ST_PERIPH] || (|periph_set);
        status_d[`PWF_ST_WAKE] = status_d[`PWF_ST_WAKE] || (|wake_set);
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            status_q <= `PWF_ST_RST;
            irq_q <= 1'b0;
        end else begin
            status_q <= status_d;
            irq_q <= |(status_q & mask_q);
        end
    end

    // ****************************************
    // read port
    // ****************************************
    assign wflag_rd = 8'(wakeup_flag_reg_q);

    // data stand only in the cycle after the strobe; otherwise zero
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            rdata_q <= `PWF_RST_BYTE;
        end else if (bus_req.rd) begin
            case (bus_req.addr)
                `PWF_ADDR_PFLAG: rdata_q <= peripheral_flag_reg_q;
                `PWF_ADDR_WFLAG: rdata_q <= wflag_rd;
                `PWF_ADDR_PEN: rdata_q <= periph_enable_q;
                `PWF_ADDR_WEDGE: rdata_q <= 8'(wakeup_edge_select_q);
                `PWF_ADDR_WEN: rdata_q <= 8'(wakeup_irq_enable_q);
                `PWF_ADDR_STAT: rdata_q <= 8'(status_q);
                `PWF_ADDR_MASK: rdata_q <= 8'(mask_q);
                default: rdata_q <= `PWF_RST_BYTE;
            endcase
        end else begin
            rdata_q <= `PWF_RST_BYTE;
        end
    end

    assign rdata = rdata_q;
    assign periph_irq_req = periph_irq_req_q;
    assign wakeup_irq_req = wakeup_irq_req_q;
    assign irq = irq_q;

    // ****************************************
    // checks
    // ****************************************
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!arst_n);

    sequence s_pflag_read;
        bus_req.rd && bus_req.addr == `PWF_ADDR_PFLAG;
    endsequence

    property p_flag_readback;
        s_pflag_read |=> rdata == $past(peripheral_flag_reg_q);
    endproperty
    a_flag_readback: assert property (p_flag_readback) else $error("flag read data wrong");

    property p_no_sw_set;
        ((peripheral_flag_reg_q & ~$past(peripheral_flag_reg_q) & `PWF_FLAG_MASK) &
         ~$past(periph_set)) == `PWF_RST_BYTE;
    endproperty
    a_no_sw_set: assert property (p_no_sw_set) else $error("flag rose without an event");

    property p_hold_no_write;
        !wr_pflag |=> (peripheral_flag_reg_q & $past(peripheral_flag_reg_q)) == $past(peripheral_flag_reg_q);
    endproperty
    a_hold_no_write: assert property (p_hold_no_write) else $error("flag lost without a write");

    property p_direct_set;
        periph_ev.sleep_direct && periph_ev.direct_transfer_on |=> peripheral_flag_reg_q[`PWF_BIT_DT];
    endproperty
    a_direct_set: assert property (p_direct_set) else $error("direct transfer flag not set");

    property p_rsv_rw;
        wr_pflag |=> peripheral_flag_reg_q[`PWF_BIT_RSV] == $past(bus_req.wdata[`PWF_BIT_RSV]);
    endproperty
    a_rsv_rw: assert property (p_rsv_rw) else $error("reserved bit not written");

    property p_tc_wrap;
        sample_valid_q && tc_prev_q == `PWF_CNT_MAX && periph_ev.timer_c_count == `PWF_CNT_ZERO
            |=> peripheral_flag_reg_q[`PWF_BIT_TC];
    endproperty
    a_tc_wrap: assert property (p_tc_wrap) else $error("timer C wrap missed");

    property p_wake_clear;
        wr_wflag && !bus_req.wdata[0] && !wake_set[0] |=> !wakeup_flag_reg_q[0];
    endproperty
    a_wake_clear: assert property (p_wake_clear) else $error("wakeup flag not cleared");

    property p_set_wins;
        wr_pflag && bus_req.wdata == `PWF_RST_BYTE && periph_set[`PWF_BIT_EC]
            |=> peripheral_flag_reg_q[`PWF_BIT_EC];
    endproperty
    a_set_wins: assert property (p_set_wins) else $error("set lost to clear");

    property p_req_gate;
        ##1 periph_irq_req == ($past(peripheral_flag_reg_q) & $past(periph_enable_q) & `PWF_FLAG_MASK);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request not gated by enable");

    // edges are judged on the pins themselves, not on the detector's own history
    sequence s_wake_fall_top;
        sample_valid_q && wakeup_pin_sel[NUM_WKP-1] && !wakeup_edge_select_q[NUM_WKP-1] &&
            $fell(wakeup_pin[NUM_WKP-1]);
    endsequence

    sequence s_wake_rise_low;
        sample_valid_q && wakeup_pin_sel[0] && wakeup_edge_select_q[0] && $rose(wakeup_pin[0]);
    endsequence

    property p_wake_fall;
        s_wake_fall_top |=> wakeup_flag_reg_q[NUM_WKP-1];
    endproperty
    a_wake_fall: assert property (p_wake_fall) else $error("wakeup falling edge missed");

    property p_wake_rise;
        s_wake_rise_low |=> wakeup_flag_reg_q[0];
    endproperty
    a_wake_rise: assert property (p_wake_rise) else $error("wakeup rising edge missed");

    property p_conv_done;
        sample_valid_q && $fell(periph_ev.converter_start_busy) |=> peripheral_flag_reg_q[`PWF_BIT_AD];
    endproperty
    a_conv_done: assert property (p_conv_done) else $error("conversion done flag not set");

    property p_tfl_match;
        sample_valid_q && !periph_ev.tf_mode16 && $rose(tfl_match) |=> peripheral_flag_reg_q[`PWF_BIT_TFL];
    endproperty
    a_tfl_match: assert property (p_tfl_match) else $error("timer F low match missed");

    property p_tfh_match16;
        sample_valid_q && periph_ev.tf_mode16 && $rose(tfh_match) |=> peripheral_flag_reg_q[`PWF_BIT_TFH];
    endproperty
    a_tfh_match16: assert property (p_tfh_match16) else $error("timer F full match missed");

    property p_ec_high;
        periph_ev.event_count_high_ovf |=> peripheral_flag_reg_q[`PWF_BIT_EC];
    endproperty
    a_ec_high: assert property (p_ec_high) else $error("event counter high overflow missed");

    property p_tc_underflow;
        sample_valid_q && $past(periph_ev.timer_c_count) == `PWF_CNT_ZERO &&
            periph_ev.timer_c_count == `PWF_CNT_MAX |=> peripheral_flag_reg_q[`PWF_BIT_TC];
    endproperty
    a_tc_underflow: assert property (p_tc_underflow) else $error("timer C underflow missed");

endmodule

// ==== tb/pwf_ev_model.sv ====
`timescale 1ns/100ps
// ************
// event sources
// ************
module pwf_ev_model
    import pwf_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic arst_n,
    // command
    input wire logic go,
    input wire logic [2:0] code,
    input wire logic mode16,
    // events
    output pwf_periph_ev_t ev
);
    logic wrap_q;

    // every event lasts one cycle, so one command gives at most one set
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ev <= '0;
            wrap_q <= 1'b0;
        end else begin
            ev <= '0;
            ev.direct_transfer_on <= 1'b1;
            ev.timer_g_capture_pin <= 1'b1;
            ev.overflow_irq_enable <= 1'b1;
            ev.tf_mode16 <= mode16;
            ev.ec_mode16 <= mode16;
            ev.timer_f_compare_high <= 8'h5a;
            ev.timer_f_compare_low <= 8'ha5;
            // a wrap command crosses the end once, then the count parks at 7f
            wrap_q <= go && code == 3'h1;
            ev.timer_c_count <= wrap_q ? ~ev.timer_c_count : 8'h7f;
            if (go) begin
                case (code)
                    3'h7: ev.sleep_direct <= 1'b1;
                    3'h6: ev.converter_start_busy <= 1'b1;
                    3'h5: ev.tg_overflow <= 1'b1;
                    3'h4: ev.tg_capture_edge <= 1'b1;
                    // in 16-bit mode only the full match counts
                    3'h3: begin
                        ev.timer_f_count_high <= 8'h5a;
                        ev.timer_f_count_low <= mode16 ? 8'ha5 : 8'h00;
                    end
                    // low-half events must be ignored in 16-bit mode
                    3'h2: begin
                        ev.timer_f_count_low <= 8'ha5;
                        ev.event_count_low_ovf <= mode16;
                    end
                    // overflow on the 8-bit pass, underflow on the 16-bit pass
                    3'h1: ev.timer_c_count <= mode16 ? 8'h00 : 8'hff;
                    default: begin
                        ev.event_count_low_ovf <= !mode16;
                        ev.event_count_high_ovf <= mode16;
                    end
                endcase
            end
        end
    end
endmodule

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
`include "pwf_defines.svh"
// ************
// bench top
// ************
module testbench;
    import pwf_pkg::*;
    logic clk_sys = 1'b0;
    logic arst_n = 1'b0;
    logic go = 1'b0;
    logic [2:0] code = 3'h0;
    logic mode16 = 1'b0;
    pwf_bus_req_t bus_req = '0;
    logic [7:0] wakeup_pin = 8'hff;
    logic [7:0] wakeup_pin_sel = 8'h00;
    logic [7:0] rdata, periph_irq_req, flags, w;
    logic wakeup_irq_req, irq;
    pwf_periph_ev_t periph_ev;
    int mismatches = 0;
    int n_tests = 0;
    logic [31:0] seed = 32'd52864;
    always #20 clk_sys = ~clk_sys;
    pwf_ev_model pwf_ev_model_i (.clk_sys(clk_sys), .arst_n(arst_n), .go(go), .code(code), .mode16(mode16),
        .ev(periph_ev));
    pwf_irq_flags pwf_irq_flags_i (.clk_sys(clk_sys), .arst_n(arst_n), .bus_req(bus_req), .rdata(rdata),
        .periph_ev(periph_ev), .wakeup_pin(wakeup_pin), .wakeup_pin_sel(wakeup_pin_sel),
        .periph_irq_req(periph_irq_req), .wakeup_irq_req(wakeup_irq_req), .irq(irq));
    function automatic logic [7:0] flag_of(input logic [2:0] c, input logic m16);
        // low-half sources are ignored in 16-bit mode
        if (m16 && c == 3'h2) begin
            return 8'h00;
        end
        return (c == 3'h5) ? 8'h10 : (8'h01 << c);
    endfunction
    task automatic rnd(output logic [7:0] v);
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        v = seed[7:0];
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
        n_tests++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk_bit(input logic got, input logic exp);
        chk_byte({7'h00, got}, {7'h00, exp});
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus_req.wr <= 1'b0;
    endtask
    // read data stands only in the cycle after the strobe
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus_req.rd <= 1'b0;
        @(negedge clk_sys);
        chk_byte(rdata, exp);
    endtask
    task automatic fire(input logic [2:0] c);
        @(posedge clk_sys);
        go <= 1'b1;
        code <= c;
        @(posedge clk_sys);
        go <= 1'b0;
        repeat (3) @(posedge clk_sys);
    endtask
    task automatic end_test(input string name);
        $display("test %s done, %0d checks", name, n_tests);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_tests, mismatches);
        if (mismatches == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // the sequence needs well under a thousand cycles
    initial begin
        #(40 * 4000);
        mismatches++;
        tally_and_finish();
    end
    initial begin
        repeat (2) @(posedge clk_sys);
        arst_n <= 1'b1;
        for (int a = 0; a < 7; a++) begin
            rd_chk(a[3:0], 8'h00);
        end
        end_test("reset");
        wr(`PWF_ADDR_PFLAG, 8'hff);
        rd_chk(`PWF_ADDR_PFLAG, 8'h20);
        wr(`PWF_ADDR_WFLAG, 8'hff);
        rd_chk(`PWF_ADDR_WFLAG, 8'h00);
        wr(`PWF_ADDR_PFLAG, 8'h00);
        rd_chk(`PWF_ADDR_PFLAG, 8'h00);
        end_test("write_one");
        for (int m = 0; m < 2; m++) begin
            mode16 <= m[0];
            rnd(w);
            for (int i = 0; i < 8; i++) begin
                fire(3'(i + w[2:0]));
                rd_chk(`PWF_ADDR_PFLAG, flag_of(3'(i + w[2:0]), m[0]));
                chk_byte(periph_irq_req, 8'h00);
                chk_bit(irq, 1'b0);
                wr(`PWF_ADDR_PFLAG, 8'h00);
            end
        end
        mode16 <= 1'b0;
        end_test("sources");
        wr(`PWF_ADDR_MASK, 8'h01);
        repeat (2) @(negedge clk_sys);
        chk_bit(irq, 1'b1);
        rd_chk(`PWF_ADDR_STAT, 8'h01);
        // the line follows the status one cycle later
        @(negedge clk_sys);
        chk_bit(irq, 1'b0);
        end_test("status");
        fire(3'h7);
        fire(3'h6);
        fire(3'h3);
        fire(3'h1);
        flags = 8'hca;
        rnd(w);
        wr(`PWF_ADDR_PEN, w);
        repeat (20) @(negedge clk_sys);
        chk_byte(periph_irq_req, flags & w & 8'hdf);
        rnd(w);
        wr(`PWF_ADDR_PFLAG, w);
        rd_chk(`PWF_ADDR_PFLAG, (flags & w & 8'hdf) | (w & 8'h20));
        end_test("enable_clear");
        // the clearing write and the event land on the same edge
        fork
            fire(3'h0);
            begin
                @(posedge clk_sys);
                wr(`PWF_ADDR_PFLAG, 8'h00);
            end
        join
        rd_chk(`PWF_ADDR_PFLAG, 8'h01);
        end_test("set_wins");
        wr(`PWF_ADDR_MASK, 8'h02);
        wr(`PWF_ADDR_WEDGE, 8'h0f);
        wr(`PWF_ADDR_WEN, 8'h01);
        rnd(w);
        w = w | 8'h81;
        @(posedge clk_sys);
        wakeup_pin_sel <= w;
        repeat (2) @(posedge clk_sys);
        wakeup_pin <= 8'h00;
        rd_chk(`PWF_ADDR_WFLAG, w & 8'hf0);
        @(posedge clk_sys);
        wakeup_pin <= 8'hff;
        rd_chk(`PWF_ADDR_WFLAG, w);
        chk_bit(wakeup_irq_req, 1'b1);
        chk_bit(irq, 1'b1);
        wr(`PWF_ADDR_WFLAG, 8'hfe);
        rd_chk(`PWF_ADDR_WFLAG, w & 8'hfe);
        end_test("wakeup");
        tally_and_finish();
    end
endmodule
